// file: src/smi_pkg.sv
// shared constants and types for the serial management bus monitor
package smi_pkg;

   // ***********************************************************
   // bus addresses
   // ***********************************************************
   localparam logic [6:0] OWN_ADDR       = 7'h2e;
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;

   // ***********************************************************
   // register offsets, fields, reset values
   // ***********************************************************
   localparam logic [7:0] REG_CHIPSET_READING = 8'h21;
   localparam logic [7:0] REG_OWN_READING     = 8'h22;
   localparam logic [7:0] REG_CONFIG_ONE      = 8'h40;
   localparam logic [7:0] REG_STATUS_ONE      = 8'h41;
   localparam logic [7:0] REG_CHIPSET_LOW     = 8'h46;
   localparam logic [7:0] REG_CHIPSET_HIGH    = 8'h47;
   localparam int         CFG_TIMEOUT_DIS_BIT = 6;
   localparam int         STAT_LOW_BIT        = 0;
   localparam int         STAT_HIGH_BIT       = 1;
   localparam logic [7:0] RST_READING         = 8'h00;
   localparam logic [7:0] RST_CONFIG_ONE      = 8'h00;
   localparam logic [7:0] RST_STATUS_ONE      = 8'h00;
   localparam logic [7:0] RST_CHIPSET_LOW     = 8'h00;
   localparam logic [7:0] RST_CHIPSET_HIGH    = 8'hff;

   // ***********************************************************
   // converter and timing
   // ***********************************************************
   localparam int         CODE_W        = 10;
   localparam logic [9:0] NOMINAL_CODE  = 10'h300;
   localparam int         AVG_COUNT     = 16;
   localparam int         AVG_SHIFT     = 4;
   localparam logic [3:0] AVG_LAST      = 4'(AVG_COUNT - 1);
   localparam int         CLK_PERIOD_NS = 40;
   localparam int         TIMEOUT_MS    = 35;
   localparam int         CONV_TIME_NS  = 711000;
   localparam int         TIMEOUT_CYCLES = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int         CONV_CYCLES    = CONV_TIME_NS / CLK_PERIOD_NS;

   typedef enum {
      LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_CMD, LK_CMD_ACK,
      LK_DATA, LK_DATA_ACK, LK_TX, LK_TX_ACK
   } smi_link_state_type;

endpackage

// file: src/smi_avg_if.sv
// carrier between the conversion timer and a channel averager
`timescale 1ns/1ps
interface smi_avg_if;
   logic       strobe;
   logic [9:0] code;
   logic [9:0] avg;
   logic       avg_valid;
   modport src (output strobe, output code, input avg, input avg_valid);
   // modport name kept apart from the avg signal: one scope, one name
   modport sink (input strobe, input code, output avg, output avg_valid);
endinterface

// file: src/smi_averager.sv
// sixteen-sample averager for one voltage channel
`timescale 1ns/1ps
module smi_averager
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic en,
   smi_avg_if.sink   p
);
   logic [13:0] acc_r;
   logic [3:0]  cnt_r;
   logic [9:0]  avg_r;
   logic        valid_r;
   wire  [13:0] acc_sum = acc_r + {4'h0, p.code};
   wire         last    = (cnt_r == smi_pkg::AVG_LAST);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         acc_r   <= 14'h0000;
         cnt_r   <= 4'h0;
         avg_r   <= 10'h000;
         valid_r <= 1'b0;
      end
      else if (en)
      begin
         valid_r <= p.strobe & last;
         if (p.strobe)
         begin
            cnt_r <= cnt_r + 4'h1;
            acc_r <= last ? 14'h0000 : acc_sum;
            if (last)
               avg_r <= acc_sum[13:smi_pkg::AVG_SHIFT];
         end
      end
   end

   assign p.avg       = avg_r;
   assign p.avg_valid = valid_r;

   a_avg_sixteen: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(valid_r) |-> $past(cnt_r) == 4'hf && $past(p.strobe))
      else $error("average published without sixteen samples");

endmodule // smi_averager

// file: src/smi_monitor.sv
// serial management-bus target with supply monitor, limits and bus timeout
`timescale 1ns/1ps
module smi_monitor
#(
   parameter int TIMEOUT_CYCLES = smi_pkg::TIMEOUT_CYCLES,
   parameter int CONV_CYCLES    = smi_pkg::CONV_CYCLES
)
(
   input  wire logic       REF_CLK,
   input  wire logic       NRST,
   input  wire logic       CLK_EN,
   input  wire logic       SCL_CLK,
   input  wire logic       SDA_I,
   output wire logic       SDA_O,
   output wire logic       SDA_OE,
   output wire logic       ALERT_N_O,
   output wire logic       ALERT_N_OE,
   input  wire logic [9:0] CHIPSET_SUPPLY_CODE,
   input  wire logic [9:0] OWN_SUPPLY_CODE
);

   // ***********************************************************
   // link domain: synchronisers into the bus clock
   // ***********************************************************
   logic lrst_s1, lrst_s2, len_s1, len_s2;
   logic alert_s1, alert_s2, abort_s1, abort_s2, rdy_s1, rdy_s2;
   logic abort_t_r, rdy_t_r, alert_r;

   always_ff @(negedge SCL_CLK)
   begin
      lrst_s1  <= NRST;
      lrst_s2  <= lrst_s1;
      len_s1   <= CLK_EN;
      len_s2   <= len_s1;
      alert_s1 <= alert_r;
      alert_s2 <= alert_s1;
      abort_s1 <= abort_t_r;
      abort_s2 <= abort_s1;
      rdy_s1   <= rdy_t_r;
      rdy_s2   <= rdy_s1;
   end

   // ***********************************************************
   // link domain: bit engine
   // ***********************************************************
   smi_pkg::smi_link_state_type st_r, st_nxt;
   logic       sda_hi_r;
   logic [2:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, ptr_r, ptr_nxt, wdat_r, wdat_nxt, tx_r, tx_nxt, lrd_r;
   logic [7:0] rd_byte_r;
   logic       rd_r, rd_nxt, ara_r, ara_nxt, oe_r, oe_nxt;
   logic       ptr_go, wr_go, rdn_go;
   logic       ptr_t_r, wr_t_r, rdn_t_r, act_t_r, abort_seen_r, rdy_seen_r;

   // start/stop seen as sda differing between rising and falling scl edge
   wire       lrst_n  = lrst_s2;
   wire       start   = sda_hi_r & ~SDA_I;
   wire       stop    = ~sda_hi_r & SDA_I;
   wire       abort   = abort_s2 ^ abort_seen_r;
   wire [7:0] byte_in = {sh_r[6:0], sda_hi_r};
   wire       last    = (cnt_r == 3'h7);
   wire       own_w   = (byte_in == {smi_pkg::OWN_ADDR, 1'b0});
   wire       own_r   = (byte_in == {smi_pkg::OWN_ADDR, 1'b1});
   wire       ara_hit = (byte_in == {smi_pkg::ALERT_RESP_ADDR, 1'b1}) & alert_s2;
   wire       lrd_new = (rdy_s2 != rdy_seen_r) && (st_r != smi_pkg::LK_TX);

   always_ff @(posedge SCL_CLK)
      sda_hi_r <= SDA_I;

   always_comb
   begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r + 3'h1;
      ptr_nxt  = ptr_r;
      wdat_nxt = wdat_r;
      tx_nxt   = tx_r;
      rd_nxt   = rd_r;
      ara_nxt  = ara_r;
      oe_nxt   = 1'b0;
      ptr_go   = 1'b0;
      wr_go    = 1'b0;
      rdn_go   = 1'b0;
      if (abort || stop)
         st_nxt = smi_pkg::LK_IDLE;
      else if (start)
      begin
         st_nxt  = smi_pkg::LK_ADDR;
         cnt_nxt = 3'h0;
      end
      else
      begin
         case (st_r)
            smi_pkg::LK_ADDR:
               if (last)
               begin
                  st_nxt  = smi_pkg::LK_IDLE;
                  rd_nxt  = own_r | ara_hit;
                  ara_nxt = ara_hit;
                  tx_nxt  = ara_hit ? {smi_pkg::OWN_ADDR, 1'b0} : lrd_r;
                  if (own_w || own_r || ara_hit)
                  begin
                     st_nxt = smi_pkg::LK_ADDR_ACK;
                     oe_nxt = 1'b1;
                  end
               end
            smi_pkg::LK_ADDR_ACK:
            begin
               cnt_nxt = 3'h0;
               st_nxt  = rd_r ? smi_pkg::LK_TX : smi_pkg::LK_CMD;
               oe_nxt  = rd_r & ~tx_r[7];
               tx_nxt  = {tx_r[6:0], 1'b0};
            end
            smi_pkg::LK_CMD:
               if (last)
               begin
                  ptr_nxt = byte_in;
                  ptr_go  = 1'b1;
                  oe_nxt  = 1'b1;
                  st_nxt  = smi_pkg::LK_CMD_ACK;
               end
            smi_pkg::LK_CMD_ACK:
            begin
               cnt_nxt = 3'h0;
               st_nxt  = smi_pkg::LK_DATA;
            end
            smi_pkg::LK_DATA:
               if (last)
               begin
                  wdat_nxt = byte_in;
                  wr_go    = 1'b1;
                  oe_nxt   = 1'b1;
                  st_nxt   = smi_pkg::LK_DATA_ACK;
               end
            smi_pkg::LK_TX:
               if (last)
               begin
                  st_nxt = smi_pkg::LK_TX_ACK;
                  rdn_go = ~ara_r;
               end
               else
               begin
                  oe_nxt = ~tx_r[7];
                  tx_nxt = {tx_r[6:0], 1'b0};
               end
            default:
               st_nxt = smi_pkg::LK_IDLE;
         endcase
      end
   end

   always_ff @(negedge SCL_CLK)
   begin
      if (!lrst_n)
      begin
         st_r <= smi_pkg::LK_IDLE;
         {cnt_r, sh_r, ptr_r, wdat_r, tx_r, lrd_r} <= 43'h0;
         {rd_r, ara_r, oe_r, ptr_t_r, wr_t_r, rdn_t_r, act_t_r} <= 7'h00;
         {abort_seen_r, rdy_seen_r} <= 2'h0;
      end
      else if (len_s2)
      begin
         st_r         <= st_nxt;
         cnt_r        <= cnt_nxt;
         sh_r         <= byte_in;
         ptr_r        <= ptr_nxt;
         wdat_r       <= wdat_nxt;
         tx_r         <= tx_nxt;
         rd_r         <= rd_nxt;
         ara_r        <= ara_nxt;
         oe_r         <= oe_nxt & ~abort;
         ptr_t_r      <= ptr_t_r ^ ptr_go;
         wr_t_r       <= wr_t_r ^ wr_go;
         rdn_t_r      <= rdn_t_r ^ rdn_go;
         act_t_r      <= ~act_t_r;
         abort_seen_r <= abort_s2;
         if (lrd_new)
         begin
            lrd_r      <= rd_byte_r;
            rdy_seen_r <= rdy_s2;
         end
      end
   end

   // ***********************************************************
   // reference domain: event crossings from the link
   // ***********************************************************
   logic [2:0] ptr_s, wr_s, rdn_s, act_s;
   logic [1:0] ack_s;
   always_ff @(posedge REF_CLK)
   begin
      ptr_s <= {ptr_s[1:0], ptr_t_r};
      wr_s  <= {wr_s[1:0], wr_t_r};
      rdn_s <= {rdn_s[1:0], rdn_t_r};
      act_s <= {act_s[1:0], act_t_r};
      ack_s <= {ack_s[0], rdy_seen_r};
   end
   wire ptr_evt = ptr_s[2] ^ ptr_s[1];
   wire wr_evt  = wr_s[2] ^ wr_s[1];
   wire rdn_evt = rdn_s[2] ^ rdn_s[1];
   wire act_evt = act_s[2] ^ act_s[1];
   wire rd_pend = rdy_t_r ^ ack_s[1];

   // ***********************************************************
   // reference domain: register file
   // ***********************************************************
   logic [7:0] ptr_ref_r, cfg_r, stat_r, low_r, high_r, chip_rd_r, own_rd_r;
   logic [7:0] stat_nxt;
   wire        timeout_dis = cfg_r[smi_pkg::CFG_TIMEOUT_DIS_BIT];
   // write word is stable: next write is at least 18 bus clocks away
   wire        wr_cfg  = wr_evt && ptr_r == smi_pkg::REG_CONFIG_ONE;
   wire        wr_low  = wr_evt && ptr_r == smi_pkg::REG_CHIPSET_LOW;
   wire        wr_high = wr_evt && ptr_r == smi_pkg::REG_CHIPSET_HIGH;
   wire        clr_stat = rdn_evt && ptr_ref_r == smi_pkg::REG_STATUS_ONE;
   wire        below   = chip_rd_r < low_r;
   wire        above   = chip_rd_r > high_r;
   wire [7:0]  rd_mux  =
      (ptr_ref_r == smi_pkg::REG_CHIPSET_READING) ? chip_rd_r :
      (ptr_ref_r == smi_pkg::REG_OWN_READING)     ? own_rd_r  :
      (ptr_ref_r == smi_pkg::REG_CONFIG_ONE)      ? cfg_r     :
      (ptr_ref_r == smi_pkg::REG_STATUS_ONE)      ? stat_r    :
      (ptr_ref_r == smi_pkg::REG_CHIPSET_LOW)     ? low_r     :
      (ptr_ref_r == smi_pkg::REG_CHIPSET_HIGH)    ? high_r    : 8'h00;

   // set wins over the clear-on-read
   always_comb
   begin
      stat_nxt = stat_r & ~{8{clr_stat}};
      stat_nxt[smi_pkg::STAT_LOW_BIT]  = stat_nxt[smi_pkg::STAT_LOW_BIT] | below;
      stat_nxt[smi_pkg::STAT_HIGH_BIT] = stat_nxt[smi_pkg::STAT_HIGH_BIT] | above;
   end

   smi_avg_if chip_if ();
   smi_avg_if own_if ();

   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         ptr_ref_r <= 8'h00;
         cfg_r     <= smi_pkg::RST_CONFIG_ONE;
         stat_r    <= smi_pkg::RST_STATUS_ONE;
         low_r     <= smi_pkg::RST_CHIPSET_LOW;
         high_r    <= smi_pkg::RST_CHIPSET_HIGH;
         chip_rd_r <= smi_pkg::RST_READING;
         own_rd_r  <= smi_pkg::RST_READING;
         alert_r   <= 1'b0;
         rd_byte_r <= 8'h00;
         rdy_t_r   <= 1'b0;
      end
      else if (CLK_EN)
      begin
         if (ptr_evt)
            ptr_ref_r <= ptr_r;
         if (wr_cfg)
            cfg_r <= wdat_r;
         if (wr_low)
            low_r <= wdat_r;
         if (wr_high)
            high_r <= wdat_r;
         // nominal code 0x300 reads as 0xc0: top eight of ten bits
         if (chip_if.avg_valid)
            chip_rd_r <= chip_if.avg[9:2];
         if (own_if.avg_valid)
            own_rd_r <= own_if.avg[9:2];
         stat_r  <= stat_nxt;
         alert_r <= |stat_nxt;
         if (!rd_pend)
         begin
            rd_byte_r <= rd_mux;
            rdy_t_r   <= ~rdy_t_r;
         end
      end
   end

   // ***********************************************************
   // reference domain: conversion timer and averagers
   // ***********************************************************
   logic [14:0] conv_cnt_r;
   wire         conv_tick = (conv_cnt_r == 15'(CONV_CYCLES - 1));
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
         conv_cnt_r <= 15'h0000;
      else if (CLK_EN)
         conv_cnt_r <= conv_tick ? 15'h0000 : conv_cnt_r + 15'h0001;
   end

   assign chip_if.strobe = conv_tick & CLK_EN;
   assign chip_if.code   = CHIPSET_SUPPLY_CODE;
   assign own_if.strobe  = conv_tick & CLK_EN;
   assign own_if.code    = OWN_SUPPLY_CODE;

   smi_averager u_chip_avg (.clk(REF_CLK), .rst_n(NRST), .en(CLK_EN), .p(chip_if.sink));
   smi_averager u_own_avg  (.clk(REF_CLK), .rst_n(NRST), .en(CLK_EN), .p(own_if.sink));

   // ***********************************************************
   // reference domain: bus timeout
   // ***********************************************************
   logic [19:0] idle_cnt_r;
   logic        locked_r;
   wire         idle_hit = (idle_cnt_r == 20'(TIMEOUT_CYCLES - 1));
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         idle_cnt_r <= 20'h00000;
         locked_r   <= 1'b0;
         abort_t_r  <= 1'b0;
      end
      else if (CLK_EN)
      begin
         idle_cnt_r <= act_evt ? 20'h00000 : (idle_hit ? idle_cnt_r : idle_cnt_r + 20'h00001);
         locked_r   <= ~act_evt & ~timeout_dis & (idle_hit | locked_r);
         abort_t_r  <= abort_t_r ^ (idle_hit & ~locked_r & ~timeout_dis & ~act_evt);
      end
   end

   // open-drain pins: only ever pull low
   assign SDA_O      = 1'b0;
   assign SDA_OE     = oe_r & ~locked_r;
   assign ALERT_N_O  = 1'b0;
   assign ALERT_N_OE = alert_r;

   // ***********************************************************
   // checks
   // ***********************************************************
   sequence s_addr_own;
      st_r == smi_pkg::LK_ADDR && last && !abort && !stop && !start && len_s2;
   endsequence

   a_own_ack: assert property (@(negedge SCL_CLK) disable iff (!lrst_n)
      s_addr_own and own_r |=> oe_r && st_r == smi_pkg::LK_ADDR_ACK)
      else $error("own read address not acknowledged");
   a_foreign_nack: assert property (@(negedge SCL_CLK) disable iff (!lrst_n)
      s_addr_own and !own_r && !own_w && !ara_hit |=> !oe_r ##1 !oe_r)
      else $error("foreign address acknowledged");
   a_ptr_hold: assert property (@(negedge SCL_CLK) disable iff (!lrst_n)
      $changed(ptr_r) |-> $past(st_r) == smi_pkg::LK_CMD)
      else $error("pointer moved outside command byte");
   a_ara_reply: assert property (@(negedge SCL_CLK) disable iff (!lrst_n)
      s_addr_own and ara_hit |=> tx_r == {smi_pkg::OWN_ADDR, 1'b0})
      else $error("alert response did not carry own address");
   a_low_status: assert property (@(posedge REF_CLK) disable iff (!NRST)
      CLK_EN && below |=> stat_r[smi_pkg::STAT_LOW_BIT] && alert_r)
      else $error("low limit breach missed");
   a_alert_holds: assert property (@(posedge REF_CLK) disable iff (!NRST)
      CLK_EN && clr_stat && above |=> ALERT_N_OE)
      else $error("alert released while condition present");
   a_timeout_release: assert property (@(posedge REF_CLK) disable iff (!NRST)
      CLK_EN && idle_hit && !timeout_dis && !act_evt |=> !SDA_OE [*2])
      else $error("bus not released after idle timeout");
   a_timeout_disabled: assert property (@(posedge REF_CLK) disable iff (!NRST)
      timeout_dis |=> !locked_r)
      else $error("timeout fired while disabled");
   a_limit_reset: assert property (@(posedge REF_CLK)
      !NRST |=> low_r == 8'h00 && high_r == 8'hff && chip_rd_r == 8'h00)
      else $error("limit or reading reset value wrong");

endmodule // smi_monitor

// file: verif/smi_host_model.sv
// bus host model: drives the serial clock and pulls the data line
`timescale 1ns/1ps
module smi_host_model
(
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   // ***********************************************************
   // bit level, 64 ns per bit, data moved mid low phase
   // ***********************************************************
   initial
   begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n)
      begin
         #32 scl = 1'b0;
         #32 scl = 1'b1;
      end
   endtask

   task automatic bit_wr(input logic b);
      #16 sda_pull = ~b;
      #16 scl = 1'b1;
      #32 scl = 1'b0;
   endtask

   task automatic bit_rd(output logic b);
      #16 sda_pull = 1'b0;
      #16 scl = 1'b1;
      #16 b = sda;
      #16 scl = 1'b0;
   endtask

   // also serves as repeated start from the low phase after an ack
   // from idle: a few released clocks first, so the link sees the last stop
   // and any pending timeout abort before the start, not inside the frame
   task automatic start();
      if (scl)
         tick(3);
      #16 sda_pull = 1'b0;
      #16 scl = 1'b1;
      #32 sda_pull = 1'b1;
      #32 scl = 1'b0;
   endtask

   task automatic stop();
      #16 sda_pull = 1'b1;
      #16 scl = 1'b1;
      #32 sda_pull = 1'b0;
      #32;
   endtask

   // ***********************************************************
   // byte level, msb first
   // ***********************************************************
   task automatic byte_wr(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
         bit_wr(d[i]);
      bit_rd(b);
      ack = ~b;
   endtask

   task automatic rx_part(input logic [6:0] a, output logic [7:0] d, output logic ok);
      start();
      byte_wr({a, 1'b1}, ok);
      d = 8'h00;
      if (ok)
      begin
         for (int i = 7; i >= 0; i--)
            bit_rd(d[i]);
         bit_wr(1'b1);
      end
      stop();
   endtask

   // ***********************************************************
   // transfers
   // ***********************************************************
   task automatic addr_cmd(input logic [7:0] cmd, output logic ok);
      logic a1;
      logic a2;
      start();
      byte_wr({smi_pkg::OWN_ADDR, 1'b0}, a1);
      byte_wr(cmd, a2);
      ok = a1 & a2;
   endtask

   task automatic send_cmd(input logic [7:0] cmd, output logic ok);
      addr_cmd(cmd, ok);
      stop();
   endtask

   task automatic write_byte(input logic [7:0] cmd, input logic [7:0] d, output logic ok);
      logic a1;
      logic a2;
      addr_cmd(cmd, a1);
      byte_wr(d, a2);
      stop();
      ok = a1 & a2;
   endtask

   // pointer set then read with no stop in between
   task automatic read_reg(input logic [7:0] cmd, output logic [7:0] d, output logic ok);
      logic a1;
      logic a2;
      addr_cmd(cmd, a1);
      rx_part(smi_pkg::OWN_ADDR, d, a2);
      ok = a1 & a2;
   endtask

   // plain receive byte, or alert response read when a is that address
   task automatic receive(input logic [6:0] a, output logic [7:0] d, output logic ok);
      rx_part(a, d, ok);
   endtask
endmodule // smi_host_model

// file: verif/tb_top.sv
// self-checking bench for the serial management-bus monitor
`timescale 1ns/1ps
module tb_top;
   localparam int TO_CYC   = 300;
   localparam int CONV_CYC = 64;
   logic       REF_CLK = 1'b0;
   logic       NRST;
   logic       CLK_EN;
   logic [9:0] chip_code;
   logic [9:0] own_code;
   wire        sda_line;
   wire        scl;
   wire        host_pull;
   wire        sda_o;
   wire        sda_oe;
   wire        alert_o;
   wire        alert_oe;
   int         mismatches  = 0;
   int         checks_done = 0;
   int         cycles      = 0;
   logic [7:0] d;
   logic       ok;

   always #20 REF_CLK = ~REF_CLK;
   // released line floats high through the pull-up; wired-and lets any puller win
   assign sda_line = ~((sda_oe & ~sda_o) | host_pull);

   smi_monitor #(.TIMEOUT_CYCLES(TO_CYC), .CONV_CYCLES(CONV_CYC)) u_smi_monitor
   (
      .REF_CLK(REF_CLK), .NRST(NRST), .CLK_EN(CLK_EN), .SCL_CLK(scl), .SDA_I(sda_line),
      .SDA_O(sda_o), .SDA_OE(sda_oe), .ALERT_N_O(alert_o), .ALERT_N_OE(alert_oe),
      .CHIPSET_SUPPLY_CODE(chip_code), .OWN_SUPPLY_CODE(own_code)
   );
   smi_host_model u_smi_host_model (.scl(scl), .sda_pull(host_pull), .sda(sda_line));

   // ***********************************************************
   // helpers
   // ***********************************************************
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask

   task automatic rd(input logic [7:0] cmd, output logic [7:0] v);
      logic k;
      u_smi_host_model.read_reg(cmd, v, k);
      chk("read_ack", 8'h01, {7'h0, k});
   endtask

   task automatic wr(input logic [7:0] cmd, input logic [7:0] v);
      logic k;
      u_smi_host_model.write_byte(cmd, v, k);
      chk("write_ack", 8'h01, {7'h0, k});
   endtask

   // stall with the ack clock low until the idle limit has passed
   task automatic hang(output logic oe);
      logic b;
      u_smi_host_model.start();
      for (int i = 7; i >= 0; i--)
         u_smi_host_model.bit_wr(smi_pkg::OWN_ADDR[i > 0 ? i - 1 : 0] | (i == 0 ? 1'b0 : 1'b0));
      repeat (TO_CYC + 40) @(posedge REF_CLK);
      oe = sda_oe;
      u_smi_host_model.bit_rd(b);
      u_smi_host_model.stop();
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge REF_CLK)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         mismatches++;
         give_verdict();
      end
   end

   // ***********************************************************
   // tests
   // ***********************************************************
   initial
   begin
      NRST      <= 1'b0;
      CLK_EN    <= 1'b1;
      chip_code <= smi_pkg::NOMINAL_CODE;
      own_code  <= 10'h100;
      fork
         u_smi_host_model.tick(16);
      join_none
      repeat (16) @(posedge REF_CLK);
      NRST <= 1'b1;
      repeat (12) @(posedge REF_CLK);
      rd(smi_pkg::REG_CHIPSET_READING, d);
      chk("chipset_reading", smi_pkg::RST_READING, d);
      rd(smi_pkg::REG_OWN_READING, d);
      chk("own_reading", smi_pkg::RST_READING, d);
      rd(smi_pkg::REG_CONFIG_ONE, d);
      chk("config_one", smi_pkg::RST_CONFIG_ONE, d);
      rd(smi_pkg::REG_CHIPSET_LOW, d);
      chk("low_limit", 8'h00, d);
      rd(smi_pkg::REG_CHIPSET_HIGH, d);
      chk("high_limit", 8'hff, d);
      for (int i = 0; i < 2; i++)
      begin
         u_smi_host_model.receive(smi_pkg::OWN_ADDR, d, ok);
         chk("pointer_hold", 8'hff, d);
      end
      $display("test reset_and_pointer done");

      u_smi_host_model.receive(7'h2f, d, ok);
      chk("foreign_ack", 8'h00, {7'h0, ok});
      u_smi_host_model.receive(smi_pkg::ALERT_RESP_ADDR, d, ok);
      chk("ara_idle_ack", 8'h00, {7'h0, ok});
      u_smi_host_model.send_cmd(smi_pkg::REG_CHIPSET_LOW, ok);
      chk("send_ack", 8'h01, {7'h0, ok});
      u_smi_host_model.receive(smi_pkg::OWN_ADDR, d, ok);
      chk("send_pointer", 8'h00, d);
      $display("test addressing done");

      repeat (16 * CONV_CYC + 60) @(posedge REF_CLK);
      rd(smi_pkg::REG_CHIPSET_READING, d);
      chk("chipset_avg", smi_pkg::NOMINAL_CODE[9:2], d);
      rd(smi_pkg::REG_OWN_READING, d);
      chk("own_avg", own_code[9:2], d);
      wr(smi_pkg::REG_CHIPSET_READING, 8'h55);
      rd(smi_pkg::REG_CHIPSET_READING, d);
      chk("reading_ro", smi_pkg::NOMINAL_CODE[9:2], d);
      $display("test conversion done");

      wr(smi_pkg::REG_CHIPSET_HIGH, 8'h80);
      repeat (8) @(posedge REF_CLK);
      chk("alert_high", 8'h01, {7'h0, alert_oe});
      chk("alert_level", 8'h00, {7'h0, alert_o});
      u_smi_host_model.receive(smi_pkg::ALERT_RESP_ADDR, d, ok);
      chk("ara_answer", {smi_pkg::OWN_ADDR, 1'b0}, d);
      rd(smi_pkg::REG_STATUS_ONE, d);
      chk("status_high", 8'h02, d);
      chk("alert_kept", 8'h01, {7'h0, alert_oe});
      wr(smi_pkg::REG_CHIPSET_HIGH, 8'hff);
      wr(smi_pkg::REG_CHIPSET_LOW, 8'hd0);
      rd(smi_pkg::REG_STATUS_ONE, d);
      chk("status_low", 8'h03, d);
      wr(smi_pkg::REG_CHIPSET_LOW, 8'h00);
      rd(smi_pkg::REG_STATUS_ONE, d);
      rd(smi_pkg::REG_STATUS_ONE, d);
      chk("status_clear", 8'h00, d);
      repeat (4) @(posedge REF_CLK);
      chk("alert_free", 8'h00, {7'h0, alert_oe});
      $display("test alert done");

      hang(ok);
      chk("timeout_release", 8'h00, {7'h0, ok});
      wr(smi_pkg::REG_CONFIG_ONE, 8'h40);
      rd(smi_pkg::REG_CONFIG_ONE, d);
      chk("config_rw", 8'h40, d);
      hang(ok);
      chk("timeout_off", 8'h01, {7'h0, ok});
      $display("test timeout done");
      give_verdict();
   end
endmodule // tb_top
